/* File: logic/emdb_params.svh */
// shared constants for the external-master dram sequencer
`ifndef EMDB_PARAMS_SVH
`define EMDB_PARAMS_SVH

// ============================================================
// bus geometry
// ============================================================
`define EMDB_ADDR_W      28
`define EMDB_DATA_W      32
`define EMDB_COL_PAD     10'h000

// ============================================================
// operand width codes on operand_width_code
// ============================================================
`define EMDB_SIZE_LONG   2'h0
`define EMDB_SIZE_BYTE   2'h1
`define EMDB_SIZE_WORD   2'h2
`define EMDB_SIZE_LINE   2'h3

// ============================================================
// bank port width and page mode codes
// ============================================================
`define EMDB_PORT_32     2'h0
`define EMDB_PORT_8      2'h1
`define EMDB_PORT_16     2'h2
`define EMDB_PAGE_NORMAL 2'h0

// ============================================================
// reset values
// ============================================================
`define EMDB_ADDR_RST    28'h0000000
`define EMDB_DATA_RST    32'h00000000

`endif

/* File: logic/emdb_pkg.sv */
// types and beat arithmetic shared by both ends
`default_nettype none
`include "emdb_params.svh"

package emdb_pkg;

	// ============================================================
	// sequencer states, one-hot
	// ============================================================
	typedef enum logic [7:0] {
		ST_IDLE  = 8'h01,
		ST_START = 8'h02,
		ST_RCD   = 8'h04,
		ST_CAS   = 8'h08,
		ST_ACK   = 8'h10,
		ST_RPRE  = 8'h20,
		ST_CPRE  = 8'h40,
		ST_REL   = 8'h80
	} emdb_state_t;

	// log2 of the port width in bytes
	function automatic logic [1:0] emdb_port_shift(input logic [1:0] port);
		return (port == `EMDB_PORT_32) ? 2'h2 : (port == `EMDB_PORT_16) ? 2'h1 : 2'h0;
	endfunction : emdb_port_shift

	// number of dram beats for one operand on one port
	function automatic logic [4:0] emdb_beats(input logic [1:0] size, input logic [1:0] port);
		logic [4:0] nbytes;
		logic [4:0] n;
		unique case (size)
			`EMDB_SIZE_LONG: nbytes = 5'h04;
			`EMDB_SIZE_BYTE: nbytes = 5'h01;
			`EMDB_SIZE_WORD: nbytes = 5'h02;
			`EMDB_SIZE_LINE: nbytes = 5'h10;
		endcase
		n = nbytes >> emdb_port_shift(port);
		return (n == 5'h00) ? 5'h01 : n;
	endfunction : emdb_beats

endpackage : emdb_pkg
`default_nettype wire

/* File: logic/emdb_if.sv */
// pins between the external master, the sequencer and the dram
`default_nettype none
`include "emdb_params.svh"

interface emdb_if (
	input wire logic core_clk
);
	logic [27:0] m_addr;
	logic        m_addr_oe;
	logic [27:0] d_addr;
	logic        d_addr_oe;
	logic [27:0] addr;
	logic        transfer_start_n;
	logic        read_not_write;
	logic [1:0]  operand_width_code;
	logic        d_ta_n;
	logic        d_ta_oe;
	logic        transfer_acknowledge_n;
	logic [31:0] m_data;
	logic        m_data_oe;
	logic [31:0] dram_rdata;
	logic [31:0] data;
	logic        ras_n;
	logic [3:0]  cas_n;
	logic        dram_write_strobe_n;

	// wire resolution; acknowledge has a pull-up, undriven address reads as zero
	assign addr = d_addr_oe ? d_addr : (m_addr_oe ? m_addr : `EMDB_ADDR_RST);
	assign transfer_acknowledge_n = d_ta_oe ? d_ta_n : 1'b1;
	assign data = m_data_oe ? m_data : dram_rdata;

	modport dev (
		input  addr,
		input  transfer_start_n,
		input  read_not_write,
		input  operand_width_code,
		output d_addr,
		output d_addr_oe,
		output d_ta_n,
		output d_ta_oe,
		output ras_n,
		output cas_n,
		output dram_write_strobe_n
	);

	modport mst (
		output m_addr,
		output m_addr_oe,
		output transfer_start_n,
		output read_not_write,
		output operand_width_code,
		output m_data,
		output m_data_oe,
		input  transfer_acknowledge_n,
		input  data
	);
endinterface : emdb_if
`default_nettype wire

/* File: logic/emdb_dram_seq.sv */
// device end: dram strobe sequencer for external-master accesses
`default_nettype none
`include "emdb_params.svh"

// ============================================================
// dual-edge strobe cell
// ============================================================
module emdb_dual_edge #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] lvl_hi,
	input  wire logic [W-1:0] lvl_lo,
	output logic      [W-1:0] strobe_n
);
	logic [W-1:0] rise_ff;
	logic [W-1:0] fall_ff;
	logic [W-1:0] lo_ff;

	// rising edge sets the high-phase level and books the low-phase one
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rise_ff <= '0;
			lo_ff   <= '0;
		end
		else if (clk_en)
		begin
			rise_ff <= lvl_hi ^ fall_ff;
			lo_ff   <= lvl_lo;
		end
	end

	// idempotent while the rising side is frozen, so it needs no enable
	always_ff @(negedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			fall_ff <= '0;
		else
			fall_ff <= lo_ff ^ rise_ff;
	end

	// xor of two flops lets a strobe drop on a rising edge and return half a clock later
	assign strobe_n = ~(rise_ff ^ fall_ff);
endmodule : emdb_dual_edge

// ============================================================
// sequencer
// ============================================================
module emdb_dram_seq
	import emdb_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	input  wire logic       clk_en,
	emdb_if.dev             bus,
	input  wire logic       bank_hit,
	input  wire logic [1:0] bank_port_width,
	input  wire logic [1:0] bank_page_mode,
	input  wire logic       ext_addr_mux_drive_en,
	input  wire logic [1:0] rcd_extra,
	input  wire logic [1:0] cas_extra,
	input  wire logic [1:0] ras_prech_extra,
	input  wire logic [1:0] cas_prech_extra,
	input  wire logic       refresh_busy,
	output logic            refresh_hold
);
	emdb_state_t state_ff;
	emdb_state_t nxt_state;
	logic [1:0]  cnt_ff;
	logic [1:0]  nxt_cnt;
	logic [1:0]  prech_ff;
	logic [4:0]  beats_ff;
	logic [27:0] cur_ff;
	logic        rd_ff;
	logic        page_ff;
	logic        ext_addr_mux_drive_en_ff;
	logic [3:0]  lane_ff;
	logic [27:0] step_ff;
	logic [27:0] addr_ff;
	logic [27:0] nxt_addr;
	logic        addr_oe_ff;
	logic        nxt_addr_oe;
	logic        ta_n_ff;
	logic        nxt_ta_n;
	logic        ta_oe_ff;
	logic        nxt_ta_oe;
	logic        we_n_ff;
	logic        nxt_we_n;
	logic        ras_lo_ff;
	logic        cas_lo_ff;
	logic        nxt_ras_hi;
	logic        nxt_ras_lo;
	logic        nxt_cas_hi;
	logic        nxt_cas_lo;
	logic        hold_ff;
	logic        capture;
	logic        last_beat;
	logic [27:0] next_cur;

	// a start strobe is only honoured between accesses; later strobes are ignored
	assign capture   = !bus.transfer_start_n && bank_hit && (state_ff == ST_IDLE || state_ff == ST_REL);
	assign last_beat = (beats_ff == 5'h01);
	assign next_cur  = cur_ff + step_ff;

	// ============================================================
	// next-state and pin levels
	// ============================================================
	always_comb
	begin
		nxt_state   = state_ff;
		nxt_cnt     = cnt_ff;
		nxt_addr    = addr_ff;
		nxt_addr_oe = addr_oe_ff;
		nxt_ta_n    = ta_n_ff;
		nxt_ta_oe   = ta_oe_ff;
		nxt_we_n    = we_n_ff;
		nxt_ras_hi  = ras_lo_ff;
		nxt_ras_lo  = ras_lo_ff;
		nxt_cas_hi  = cas_lo_ff;
		nxt_cas_lo  = cas_lo_ff;
		unique case (state_ff)
			ST_IDLE, ST_REL:
			begin
				nxt_ta_oe = 1'b0;
				nxt_we_n  = 1'b1;
				if (capture)
					nxt_state = ST_START;
				else
					nxt_state = ST_IDLE;
			end
			ST_START:
			begin
				// hold off while precharge runs or a refresh owns the array
				if (prech_ff == 2'h0 && !refresh_busy)
				begin
					nxt_addr    = cur_ff;
					nxt_addr_oe = ext_addr_mux_drive_en_ff;
					nxt_we_n    = rd_ff;
					nxt_ras_hi  = 1'b0;
					nxt_ras_lo  = 1'b1;
					nxt_cnt     = rcd_extra;
					nxt_state   = ST_RCD;
				end
			end
			ST_RCD:
			begin
				if (cnt_ff != 2'h0)
					nxt_cnt = cnt_ff - 2'h1;
				else
				begin
					nxt_addr   = {`EMDB_COL_PAD, cur_ff[8:0], cur_ff[8:0]};
					nxt_ta_oe  = 1'b1;
					nxt_ta_n   = 1'b1;
					nxt_cas_hi = 1'b0;
					nxt_cas_lo = 1'b1;
					nxt_cnt    = cas_extra;
					nxt_state  = ST_CAS;
				end
			end
			ST_CAS:
			begin
				if (cnt_ff != 2'h0)
					nxt_cnt = cnt_ff - 2'h1;
				else
				begin
					nxt_ta_n  = 1'b0;
					nxt_state = ST_ACK;
				end
			end
			ST_ACK:
			begin
				nxt_ta_n   = 1'b1;
				nxt_cas_hi = 1'b0;
				nxt_cas_lo = 1'b0;
				if (last_beat)
				begin
					nxt_ras_hi  = 1'b0;
					nxt_ras_lo  = 1'b0;
					nxt_addr_oe = 1'b0;
					nxt_state   = ST_REL;
				end
				else if (page_ff)
				begin
					// row strobe stays; only the column changes
					nxt_addr = {`EMDB_COL_PAD, next_cur[8:0], next_cur[8:0]};
					if (cas_prech_extra == 2'h0)
					begin
						nxt_cas_lo = 1'b1;
						nxt_cnt    = cas_extra;
						nxt_state  = ST_CAS;
					end
					else
					begin
						nxt_cnt   = cas_prech_extra - 2'h1;
						nxt_state = ST_CPRE;
					end
				end
				else
				begin
					nxt_ras_hi = 1'b0;
					nxt_ras_lo = 1'b0;
					nxt_addr   = next_cur;
					nxt_cnt    = ras_prech_extra;
					nxt_state  = ST_RPRE;
				end
			end
			ST_RPRE:
			begin
				// fastest case: rise at a rising edge, back low 1.5 clocks later
				if (cnt_ff != 2'h0)
					nxt_cnt = cnt_ff - 2'h1;
				else
				begin
					nxt_ras_lo = 1'b1;
					nxt_cnt    = rcd_extra;
					nxt_state  = ST_RCD;
				end
			end
			ST_CPRE:
			begin
				if (cnt_ff != 2'h0)
					nxt_cnt = cnt_ff - 2'h1;
				else
				begin
					nxt_cas_lo = 1'b1;
					nxt_cnt    = cas_extra;
					nxt_state  = ST_CAS;
				end
			end
		endcase
	end

	// ============================================================
	// state and pin registers
	// ============================================================
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_ff   <= ST_IDLE;
			cnt_ff     <= 2'h0;
			addr_ff    <= `EMDB_ADDR_RST;
			addr_oe_ff <= 1'b0;
			ta_n_ff    <= 1'b1;
			ta_oe_ff   <= 1'b0;
			we_n_ff    <= 1'b1;
			ras_lo_ff  <= 1'b0;
			cas_lo_ff  <= 1'b0;
		end
		else if (clk_en)
		begin
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			addr_ff    <= nxt_addr;
			addr_oe_ff <= nxt_addr_oe;
			ta_n_ff    <= nxt_ta_n;
			ta_oe_ff   <= nxt_ta_oe;
			we_n_ff    <= nxt_we_n;
			ras_lo_ff  <= nxt_ras_lo;
			cas_lo_ff  <= nxt_cas_lo;
		end
	end

	// captured access; fast page banks are run as burst page
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cur_ff   <= `EMDB_ADDR_RST;
			rd_ff    <= 1'b1;
			page_ff  <= 1'b0;
			ext_addr_mux_drive_en_ff  <= 1'b0;
			lane_ff  <= 4'h0;
			step_ff  <= 28'h0000001;
			beats_ff <= 5'h01;
		end
		else if (clk_en)
		begin
			if (capture)
			begin
				cur_ff   <= bus.addr;
				rd_ff    <= bus.read_not_write;
				page_ff  <= (bank_page_mode != `EMDB_PAGE_NORMAL);
				ext_addr_mux_drive_en_ff  <= ext_addr_mux_drive_en;
				lane_ff  <= (bank_port_width == `EMDB_PORT_32) ? 4'hf :
				            (bank_port_width == `EMDB_PORT_16) ? 4'h3 : 4'h1;
				step_ff  <= 28'h0000001 << emdb_port_shift(bank_port_width);
				beats_ff <= emdb_beats(bus.operand_width_code, bank_port_width);
			end
			else if (state_ff == ST_ACK && !last_beat)
			begin
				cur_ff   <= next_cur;
				beats_ff <= beats_ff - 5'h01;
			end
		end
	end

	// precharge since the last access, and refresh lockout over the whole burst
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			prech_ff <= 2'h0;
			hold_ff  <= 1'b0;
		end
		else if (clk_en)
		begin
			if (state_ff == ST_ACK && last_beat)
				prech_ff <= ras_prech_extra;
			else if (prech_ff != 2'h0)
				prech_ff <= prech_ff - 2'h1;
			hold_ff <= (nxt_state != ST_IDLE) && (nxt_state != ST_REL);
		end
	end

	// ============================================================
	// strobes and pins
	// ============================================================
	emdb_dual_edge #(.W(1)) u_ras (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.clk_en   (clk_en),
		.lvl_hi   (nxt_ras_hi),
		.lvl_lo   (nxt_ras_lo),
		.strobe_n (bus.ras_n)
	);

	emdb_dual_edge #(.W(4)) u_cas (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.clk_en   (clk_en),
		.lvl_hi   ({4{nxt_cas_hi}} & lane_ff),
		.lvl_lo   ({4{nxt_cas_lo}} & lane_ff),
		.strobe_n (bus.cas_n)
	);

	assign bus.d_addr              = addr_ff;
	assign bus.d_addr_oe           = addr_oe_ff;
	assign bus.d_ta_n              = ta_n_ff;
	assign bus.d_ta_oe             = ta_oe_ff;
	assign bus.dram_write_strobe_n = we_n_ff;
	assign refresh_hold            = hold_ff;
endmodule : emdb_dram_seq
`default_nettype wire

/* File: logic/emdb_ext_master.sv */
// far end: external bus master issuing dram accesses
`default_nettype none
`include "emdb_params.svh"

module emdb_ext_master
	import emdb_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	emdb_if.mst              bus,
	input  wire logic        req,
	input  wire logic        req_read,
	input  wire logic [1:0]  req_size,
	input  wire logic [27:0] req_addr,
	input  wire logic [31:0] req_wdata,
	input  wire logic [1:0]  port_width,
	output logic             busy,
	output logic             done,
	output logic [31:0]      rdata
);
	logic        busy_ff;
	logic        done_ff;
	logic [31:0] rdata_ff;
	logic        ts_n_ff;
	logic        addr_oe_ff;
	logic [27:0] addr_ff;
	logic        rw_ff;
	logic [1:0]  size_ff;
	logic [1:0]  port_ff;
	logic [1:0]  lane_ff;
	logic [31:0] wdata_ff;
	logic        data_oe_ff;
	logic [4:0]  beats_ff;
	logic [31:0] acc_ff;
	logic [31:0] nxt_acc;
	logic [31:0] left_j;
	logic        take;
	logic        beat_done;

	// operand placed on the byte lanes of the target port
	function automatic logic [31:0] lane_align(input logic [31:0] op, input logic [1:0] sz,
	                                           input logic [1:0] pw, input logic [1:0] a);
		logic [31:0] l;
		l = (sz == `EMDB_SIZE_BYTE) ? {op[7:0], 24'h000000} :
		    (sz == `EMDB_SIZE_WORD) ? {op[15:0], 16'h0000} : op;
		if (pw == `EMDB_PORT_32 && sz == `EMDB_SIZE_BYTE)
			l = l >> {a, 3'h0};
		else if (pw == `EMDB_PORT_32 && sz == `EMDB_SIZE_WORD)
			l = l >> {a[1], 4'h0};
		return l;
	endfunction : lane_align

	assign take      = req && !busy_ff;
	assign beat_done = busy_ff && !bus.transfer_acknowledge_n;
	assign left_j    = bus.data << {lane_ff, 3'h0};

	// read gathering: narrow ports shift in from the top lanes, first beat most significant
	always_comb
	begin
		nxt_acc = acc_ff;
		unique case (port_ff)
			`EMDB_PORT_8:  nxt_acc = {acc_ff[23:0], bus.data[31:24]};
			`EMDB_PORT_16: nxt_acc = {acc_ff[15:0], bus.data[31:16]};
			default:
			begin
				nxt_acc = (size_ff == `EMDB_SIZE_BYTE) ? {24'h000000, left_j[31:24]} :
				          (size_ff == `EMDB_SIZE_WORD) ? {16'h0000, left_j[31:16]} : left_j;
			end
		endcase
	end

	// ============================================================
	// start strobe and address: one clock, then released
	// ============================================================
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ts_n_ff    <= 1'b1;
			addr_oe_ff <= 1'b0;
			addr_ff    <= `EMDB_ADDR_RST;
			rw_ff      <= 1'b1;
			size_ff    <= `EMDB_SIZE_LONG;
			port_ff    <= `EMDB_PORT_32;
			lane_ff    <= 2'h0;
		end
		else if (clk_en)
		begin
			ts_n_ff    <= !take;
			addr_oe_ff <= take;
			if (take)
			begin
				addr_ff <= req_addr;
				rw_ff   <= req_read;
				size_ff <= req_size;
				port_ff <= port_width;
				lane_ff <= req_addr[1:0];
			end
		end
	end

	// ============================================================
	// beats: write lanes, read gathering, completion
	// ============================================================
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			busy_ff    <= 1'b0;
			done_ff    <= 1'b0;
			rdata_ff   <= `EMDB_DATA_RST;
			wdata_ff   <= `EMDB_DATA_RST;
			data_oe_ff <= 1'b0;
			beats_ff   <= 5'h01;
			acc_ff     <= `EMDB_DATA_RST;
		end
		else if (clk_en)
		begin
			done_ff <= 1'b0;
			if (take)
			begin
				busy_ff    <= 1'b1;
				wdata_ff   <= lane_align(req_wdata, req_size, port_width, req_addr[1:0]);
				data_oe_ff <= !req_read;
				beats_ff   <= emdb_beats(req_size, port_width);
				acc_ff     <= `EMDB_DATA_RST;
			end
			else if (beat_done)
			begin
				acc_ff   <= nxt_acc;
				beats_ff <= beats_ff - 5'h01;
				// next beat's data moves up to the active lanes
				wdata_ff <= (port_ff == `EMDB_PORT_8)  ? {wdata_ff[23:0], 8'h00} :
				            (port_ff == `EMDB_PORT_16) ? {wdata_ff[15:0], 16'h0000} : wdata_ff;
				if (beats_ff == 5'h01)
				begin
					busy_ff    <= 1'b0;
					done_ff    <= 1'b1;
					data_oe_ff <= 1'b0;
					rdata_ff   <= rw_ff ? nxt_acc : rdata_ff;
				end
			end
		end
	end

	assign bus.transfer_start_n   = ts_n_ff;
	assign bus.m_addr_oe          = addr_oe_ff;
	assign bus.m_addr             = addr_ff;
	assign bus.read_not_write     = rw_ff;
	assign bus.operand_width_code = size_ff;
	assign bus.m_data             = wdata_ff;
	assign bus.m_data_oe          = data_oe_ff;
	assign busy                   = busy_ff;
	assign done                   = done_ff;
	assign rdata                  = rdata_ff;
endmodule : emdb_ext_master
`default_nettype wire

/* File: tb/emdb_link_sva.sv */
// checker: timing relations on the master-sequencer link
`default_nettype none

// ============================================================
// link checker
// ============================================================
module emdb_link_sva (
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic [27:0] addr,
	input wire logic [27:0] d_addr,
	input wire logic        d_addr_oe,
	input wire logic        m_addr_oe,
	input wire logic        transfer_start_n,
	input wire logic        read_not_write,
	input wire logic        d_ta_oe,
	input wire logic        transfer_acknowledge_n,
	input wire logic        ras_n,
	input wire logic [3:0]  cas_n,
	input wire logic        dram_write_strobe_n
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [27:0] cap_addr_ff;
	logic        cap_rnw_ff;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// keep what the start strobe carried, since the master lets go next clock
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cap_addr_ff <= 28'h0000000;
			cap_rnw_ff  <= 1'b1;
		end
		else if (!transfer_start_n)
		begin
			cap_addr_ff <= addr;
			cap_rnw_ff  <= read_not_write;
		end
	end

	a_start_release: assert property (!transfer_start_n |=>
		transfer_start_n && !m_addr_oe) else $error("start or address held after capture");
	a_row_then_col: assert property ($rose(d_addr_oe) |->
		d_addr == cap_addr_ff ##1 d_addr == {10'h000, cap_addr_ff[8:0], cap_addr_ff[8:0]})
		else $error("row or column address wrong");
	a_ack_first_neg: assert property ($rose(d_ta_oe) |-> transfer_acknowledge_n)
		else $error("acknowledge not negated when first driven");
	a_ack_one_clk: assert property (!transfer_acknowledge_n |=> transfer_acknowledge_n)
		else $error("acknowledge low longer than one clock");
	a_ack_only_hit: assert property ($rose(d_ta_oe) |-> !ras_n)
		else $error("acknowledge driven outside an open row");
	a_ras_in_beat: assert property ($fell(transfer_acknowledge_n) |->
		!ras_n && cas_n != 4'hf) else $error("strobes not active at beat end");
	a_wr_strobe_dir: assert property (!ras_n |-> dram_write_strobe_n == cap_rnw_ff)
		else $error("write strobe disagrees with direction");
	a_end_release: assert property ($fell(d_ta_oe) |->
		ras_n && cas_n == 4'hf && !d_addr_oe) else $error("bus not released after access");
endmodule : emdb_link_sva
`default_nettype wire

/* File: tb/ext_master_dram_burst_seq_test.sv */
// testbench: master and sequencer joined, accesses run from a table
`default_nettype none

module ext_master_dram_burst_seq_test import emdb_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct {
		logic rd; logic [1:0] size; logic [1:0] port; logic [1:0] page; logic [1:0] cpre;
		logic drv; logic [27:0] a; logic [31:0] wd; int beats; int span; logic [31:0] erd;
	} emdb_case_t;

	// ============================================================
	// stimulus table: direction, size, port, page mode, stretch, drive
	// ============================================================
	emdb_case_t cases [8] = '{
		'{1'b0, 2'h0, 2'h2, 2'h0, 2'h0, 1'b1, 28'h0000104, 32'h13579bdf, 2, 8, 32'h0},
		'{1'b1, 2'h0, 2'h2, 2'h0, 2'h0, 1'b1, 28'h0000104, 32'h0, 2, 8, 32'h04040606},
		'{1'b1, 2'h2, 2'h1, 2'h2, 2'h0, 1'b1, 28'h0000021, 32'h0, 2, 6, 32'h00002122},
		'{1'b1, 2'h2, 2'h1, 2'h2, 2'h1, 1'b1, 28'h0000035, 32'h0, 2, 7, 32'h00003536},
		'{1'b0, 2'h0, 2'h0, 2'h1, 2'h0, 1'b1, 28'h0000200, 32'h2468ace0, 1, 4, 32'h0},
		'{1'b0, 2'h1, 2'h1, 2'h0, 2'h0, 1'b0, 28'h0000303, 32'h0000003c, 1, 4, 32'h0},
		'{1'b1, 2'h0, 2'h1, 2'h0, 2'h1, 1'b1, 28'h0000010, 32'h0, 4, 19, 32'h10111213},
		'{1'b1, 2'h0, 2'h1, 2'h3, 2'h0, 1'b1, 28'h00000f0, 32'h0, 4, 10, 32'hf0f1f2f3}};

	logic        core_clk;
	logic        rst_b;
	logic        req;
	logic        req_read;
	logic [1:0]  req_size;
	logic [27:0] req_addr;
	logic [31:0] req_wdata;
	logic [1:0]  port_w;
	logic [1:0]  page_mode;
	logic [1:0]  cas_pre;
	logic        drive_en;
	logic        refresh_busy;
	logic        busy;
	logic        done;
	logic [31:0] rdata;
	logic        refresh_hold;
	int          errors, total_checks, cyc, start_cyc, ack_cyc, n_ack, hold_bad, oe_seen, lane_bad;

	emdb_if emdb_if_inst (.core_clk(core_clk));
	emdb_dram_seq emdb_dram_seq_inst (.core_clk(core_clk), .rst_b(rst_b), .clk_en(1'b1),
		.bus(emdb_if_inst), .bank_hit(1'b1), .bank_port_width(port_w),
		.bank_page_mode(page_mode), .ext_addr_mux_drive_en(drive_en), .rcd_extra(2'h0),
		.cas_extra(2'h0), .ras_prech_extra(cas_pre), .cas_prech_extra(cas_pre),
		.refresh_busy(refresh_busy), .refresh_hold(refresh_hold));
	emdb_ext_master emdb_ext_master_inst (.core_clk(core_clk), .rst_b(rst_b), .clk_en(1'b1),
		.bus(emdb_if_inst), .req(req), .req_read(req_read), .req_size(req_size),
		.req_addr(req_addr), .req_wdata(req_wdata), .port_width(port_w), .busy(busy),
		.done(done), .rdata(rdata));
	emdb_link_sva emdb_link_sva_inst (.core_clk(core_clk), .rst_b(rst_b),
		.addr(emdb_if_inst.addr), .d_addr(emdb_if_inst.d_addr),
		.d_addr_oe(emdb_if_inst.d_addr_oe), .m_addr_oe(emdb_if_inst.m_addr_oe),
		.transfer_start_n(emdb_if_inst.transfer_start_n),
		.read_not_write(emdb_if_inst.read_not_write), .d_ta_oe(emdb_if_inst.d_ta_oe),
		.transfer_acknowledge_n(emdb_if_inst.transfer_acknowledge_n),
		.ras_n(emdb_if_inst.ras_n), .cas_n(emdb_if_inst.cas_n),
		.dram_write_strobe_n(emdb_if_inst.dram_write_strobe_n));

	// dram answers with the column's low byte; garbage when no column strobe is low
	assign emdb_if_inst.dram_rdata = {4{emdb_if_inst.addr[7:0]}} ^ {32{&emdb_if_inst.cas_n}};

	always #50 core_clk = ~core_clk;

	// ============================================================
	// helpers
	// ============================================================
	function automatic int bits_of(input logic [1:0] c);
		return (c == 2'h1) ? 8 : (c == 2'h2) ? 16 : 32;
	endfunction : bits_of

	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic tally_and_finish();
		if (errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish

	// wire monitor at the falling edge, where rising-edge flops have settled
	always @(negedge core_clk)
	begin
		cyc++;
		if (emdb_if_inst.transfer_start_n === 1'b0) start_cyc = cyc;
		if (emdb_if_inst.d_addr_oe === 1'b1) oe_seen = 1;
		if (emdb_if_inst.transfer_acknowledge_n === 1'b0)
		begin
			ack_cyc = cyc;
			if (refresh_hold !== 1'b1) hold_bad++;
			if (!req_read && (((emdb_if_inst.data ^ ((req_wdata << (32 - bits_of(req_size)))
				<< (n_ack * bits_of(port_w)))) & ~(32'hffffffff >> bits_of(port_w))) !== 0))
				lane_bad++;
			n_ack++;
		end
	end

	// one access through the master, then its outcome at the wires
	task automatic run(input emdb_case_t c);
		int i;
		@(posedge core_clk);
		#1;
		req_read = c.rd;
		req_size = c.size;
		req_addr = c.a;
		req_wdata = c.wd;
		port_w = c.port;
		page_mode = c.page;
		cas_pre = c.cpre;
		drive_en = c.drv;
		n_ack = 0;
		oe_seen = 0;
		hold_bad = 0;
		lane_bad = 0;
		req = 1'b1;
		@(posedge core_clk);
		#1;
		req = 1'b0;
		i = 0;
		while (done !== 1'b1 && i < 80)
		begin
			@(negedge core_clk);
			i++;
		end
		check("done", {31'h0, done}, 32'h1);
		check("busy", {31'h0, busy}, 32'h0);
		check("beats", n_ack, c.beats);
		check("span", ack_cyc - start_cyc, c.span);
		check("addr drive", oe_seen, {31'h0, c.drv});
		check("refresh hold", hold_bad, 0);
		check("write lanes", lane_bad, 0);
		if (c.rd) check("rdata", rdata, c.erd);
	endtask : run

	// ============================================================
	// main sequence and watchdog
	// ============================================================
	initial
	begin
		core_clk = 1'b0;
		rst_b = 1'b0;
		req = 1'b0;
		req_read = 1'b1;
		req_size = 2'h0;
		req_addr = 28'h0000000;
		req_wdata = 32'h00000000;
		port_w = 2'h0;
		page_mode = 2'h0;
		cas_pre = 2'h0;
		drive_en = 1'b1;
		refresh_busy = 1'b0;
		errors = 0;
		total_checks = 0;
		cyc = 0;
		repeat (20) @(posedge core_clk);
		#1;
		rst_b = 1'b1;
		foreach (cases[k]) run(cases[k]);
		tally_and_finish();
	end

	// a hung access must not stall the run; whole table needs about 110 clocks
	initial
	begin
		repeat (3000) @(posedge core_clk);
		errors++;
		tally_and_finish();
	end
endmodule : ext_master_dram_burst_seq_test
`default_nettype wire
